// ### hw/pmw_defines.vh
// Purpose: constants for the power management and wake control block
// Assumes: 32-bit AHB-Lite register bus, 100 MHz hclk
// Notes: byte addresses, field positions, reset values and timing counts
`ifndef PMW_DEFINES_VH
`define PMW_DEFINES_VH

// register byte addresses
`define PMW_ADDR_HW_CONFIG 8'h74
`define PMW_ADDR_BYTE_TEST 8'h64
`define PMW_ADDR_PM_CTRL 8'h84
`define PMW_ADDR_EVENT_SRC 8'h90

// field positions in power_management_control
`define PMW_BIT_STATE_HI 13
`define PMW_BIT_STATE_LO 12
`define PMW_BIT_XCVR_RST 10
`define PMW_BIT_WAKE_LAN_ENABLE 9
`define PMW_BIT_ENERGY_DETECT_ENABLE 8
`define PMW_BIT_BUF_TYPE 6
`define PMW_BIT_WS_HI 5
`define PMW_BIT_WS_LO 4
`define PMW_BIT_PULSE_SEL 3
`define PMW_BIT_POL 2
`define PMW_BIT_OUT_EN 1
`define PMW_BIT_READY 0

// power state codes
`define PMW_STATE_NORMAL 2'h0
`define PMW_STATE_WAKE_FRAME 2'h1
`define PMW_STATE_ENERGY 2'h2
`define PMW_STATE_RESERVED 2'h3

// reset values
`define PMW_HW_CONFIG_RST 32'h00000000
`define PMW_BYTE_TEST_VAL 32'h87654321

// timing: times in ns, counts derived at 10 ns per cycle
`define PMW_CLK_PERIOD_NS 10
`define PMW_XCVR_RST_NS 100000
`define PMW_XCVR_RST_CYC ((`PMW_XCVR_RST_NS + `PMW_CLK_PERIOD_NS - 1) / `PMW_CLK_PERIOD_NS)
`define PMW_PULSE_NS 50000000
`define PMW_PULSE_CYC (`PMW_PULSE_NS / `PMW_CLK_PERIOD_NS)
`define PMW_SETTLE_CYC 16

`endif

// ### hw/pmw_counter.v
// Purpose: load-and-count-down timer with a done pulse
// Assumes: one clock, asynchronous active-low reset
// Notes: done pulses one cycle after the count reaches one
`timescale 1ns/1ps
`default_nettype none
module pmw_counter #(
  parameter WIDTH = 32
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // control
  input wire load,
  input wire [WIDTH-1:0] load_val,
  input wire cancel,
  // status
  output reg busy,
  output reg done
);
  reg [WIDTH-1:0] cnt_r;

  // count down while busy, report the final cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= {WIDTH{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        cnt_r <= load_val;
        busy <= 1'b1;
      end else if (cancel) begin
        busy <= 1'b0;
      end else if (busy) begin
        if (cnt_r <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### hw/pmw_wake_ctrl.v
// Purpose: power state, wake control and wake output behind AHB-Lite
// Assumes: hclk 100 MHz; event and wake_out_in inputs come from pins
// Notes: all outputs registered; reads take one wait state, writes none
//
// Overview of operation
// - writes ignored until first read after wake
// - bits 13-12 select normal, frame, energy
// - byte test write wakes reduced state
// - bit 10 holds transceiver reset 100us
// - bit 10 writes ignored while transceiver reset high
// - bit 9 gates wake frame events
// - bit 8 gates energy events
// - bit 6 push-pull, else open-drain active low
// - bits 5-4 report wake cause
// - write one clears wake status bit
// - status clears only when ready, sources cleared
// - bit 3 pulses 50ms, else static output
// - clearing status or enable drops output
// - bit 2 polarity, push-pull only
// - bit 1 gates only external pin
// - bit 0 ready after stabilising; after reset it sets on the first clock instead
// - control register readable in every state
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pmw_defines.vh"
module pmw_wake_ctrl #(
  parameter PULSE_CYC = `PMW_PULSE_CYC,
  parameter SETTLE_CYC = `PMW_SETTLE_CYC
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // wake event pins
  input wire wake_frame_evt,
  input wire energy_evt,
  // external wake pin, three signals
  input wire wake_out_in,
  output reg wake_out_o,
  output reg wake_out_oe,
  // internal wake interrupt and transceiver reset
  output reg wake_interrupt,
  output reg transceiver_reset,
  // current power state
  output reg [1:0] power_state
);
  // ******************************************************
  // declarations
  // ******************************************************
  reg [2:0] wf_sync_r;
  reg [2:0] ed_sync_r;
  reg wf_lvl_r;
  reg ed_lvl_r;
  reg ap_valid_r;
  reg ap_write_r;
  reg [7:0] ap_addr_r;
  reg [1:0] state_r;
  reg ready_r;
  reg read_seen_r;
  reg wake_lan_enable_r;
  reg energy_detect_enable_r;
  reg buf_type_r;
  reg [1:0] wstat_r;
  reg pulse_sel_r;
  reg pol_r;
  reg out_en_r;
  reg active_r;
  reg settling_r;
  wire wr_go;
  wire rd_go;
  wire wr_ok;
  wire wake_req;
  wire wf_rise;
  wire ed_rise;
  wire [1:0] ev_new;
  wire xr_busy;
  wire pulse_busy;
  wire pulse_done;
  wire settle_done;
  wire settle_busy;
  wire ws_clear_ok;
  wire [1:0] ws_clr;
  wire ev_any;
  wire assert_lvl;
  reg [31:0] rd_word;

  // true when address is one of the mapped words
  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `PMW_ADDR_PM_CTRL) || (a == `PMW_ADDR_BYTE_TEST) ||
                  (a == `PMW_ADDR_HW_CONFIG) || (a == `PMW_ADDR_EVENT_SRC);
    end
  endfunction

  // ******************************************************
  // input synchronisers
  // ******************************************************
  // three stages; a change counts once stages two and three agree
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wf_sync_r <= 3'h0;
      ed_sync_r <= 3'h0;
      wf_lvl_r <= 1'b0;
      ed_lvl_r <= 1'b0;
    end else begin
      wf_sync_r <= {wf_sync_r[1:0], wake_frame_evt};
      ed_sync_r <= {ed_sync_r[1:0], energy_evt};
      if (wf_sync_r[1] == wf_sync_r[2]) begin
        wf_lvl_r <= wf_sync_r[2];
      end
      if (ed_sync_r[1] == ed_sync_r[2]) begin
        ed_lvl_r <= ed_sync_r[2];
      end
    end
  end

  // event edges, each only when its enable is set
  assign wf_rise = wf_sync_r[2] && (wf_sync_r[1] == wf_sync_r[2]) && !wf_lvl_r;
  assign ed_rise = ed_sync_r[2] && (ed_sync_r[1] == ed_sync_r[2]) && !ed_lvl_r;
  assign ev_new = {wf_rise && wake_lan_enable_r, ed_rise && energy_detect_enable_r};

  // ******************************************************
  // bus address phase
  // ******************************************************
  // capture the address phase; the data phase follows next cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_addr_r <= 8'h00;
    end else if (hready) begin
      ap_valid_r <= hsel && htrans[1];
      ap_write_r <= hwrite;
      ap_addr_r <= {haddr[7:2], 2'h0};
    end
  end

  assign wr_go = ap_valid_r && ap_write_r;
  assign rd_go = hsel && htrans[1] && hready && !hwrite;
  // the byte test write is honoured in any reduced state, it is the wake path
  assign wake_req = wr_go && (ap_addr_r == `PMW_ADDR_BYTE_TEST) &&
                    (state_r != `PMW_STATE_NORMAL);
  // writes count only after a read and while ready
  assign wr_ok = wr_go && read_seen_r && ready_r;

  // ******************************************************
  // read data mux
  // ******************************************************
  // control and hw config registers always answer, other words only when ready
  always @* begin
    rd_word = 32'h00000000;
    if (ap_addr_r == `PMW_ADDR_PM_CTRL) begin
      rd_word[`PMW_BIT_STATE_HI:`PMW_BIT_STATE_LO] = state_r;
      rd_word[`PMW_BIT_XCVR_RST] = xr_busy;
      rd_word[`PMW_BIT_WAKE_LAN_ENABLE] = wake_lan_enable_r;
      rd_word[`PMW_BIT_ENERGY_DETECT_ENABLE] = energy_detect_enable_r;
      rd_word[`PMW_BIT_BUF_TYPE] = buf_type_r;
      rd_word[`PMW_BIT_WS_HI:`PMW_BIT_WS_LO] = wstat_r;
      rd_word[`PMW_BIT_PULSE_SEL] = pulse_sel_r;
      rd_word[`PMW_BIT_POL] = pol_r;
      rd_word[`PMW_BIT_OUT_EN] = out_en_r;
      rd_word[`PMW_BIT_READY] = ready_r;
    end else if (ap_addr_r == `PMW_ADDR_HW_CONFIG) begin
      rd_word = `PMW_HW_CONFIG_RST;
    end else if (ready_r && ap_addr_r == `PMW_ADDR_BYTE_TEST) begin
      rd_word = `PMW_BYTE_TEST_VAL;
    end else if (ready_r && ap_addr_r == `PMW_ADDR_EVENT_SRC) begin
      rd_word = {30'h0, wf_lvl_r, ed_lvl_r};
    end
  end

  // bus answers: a read holds hready low for one cycle so that hrdata
  // is a flip-flop loaded from state already updated by any earlier write
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (rd_go) begin
        hreadyout <= 1'b0;
      end else if (!hreadyout) begin
        hreadyout <= 1'b1;
        hrdata <= is_mapped(ap_addr_r) ? rd_word : 32'h00000000;
      end
    end
  end

  // ******************************************************
  // timers
  // ******************************************************
  pmw_counter #(.WIDTH(32)) u_xr_tmr (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(wr_ok && (ap_addr_r == `PMW_ADDR_PM_CTRL) &&
          hwdata[`PMW_BIT_XCVR_RST] && !xr_busy),
    .load_val(`PMW_XCVR_RST_CYC),
    .cancel(1'b0),
    .busy(xr_busy),
    .done()
  );

  pmw_counter #(.WIDTH(32)) u_pulse_tmr (
    .hclk(hclk),
    .hresetn(hresetn),
    .load((|ev_new) && pulse_sel_r),
    .load_val(PULSE_CYC),
    .cancel(ws_clear_ok && (|ws_clr)),
    .busy(pulse_busy),
    .done(pulse_done)
  );

  pmw_counter #(.WIDTH(32)) u_settle_tmr (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(wake_req),
    .load_val(SETTLE_CYC),
    .cancel(1'b0),
    .busy(settle_busy),
    .done(settle_done)
  );

  // ******************************************************
  // control register and power state
  // ******************************************************
  assign ws_clear_ok = wr_ok && (ap_addr_r == `PMW_ADDR_PM_CTRL) &&
                       (state_r == `PMW_STATE_NORMAL) && !wf_lvl_r && !ed_lvl_r;
  assign ws_clr = ws_clear_ok ? hwdata[`PMW_BIT_WS_HI:`PMW_BIT_WS_LO] : 2'h0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= `PMW_STATE_NORMAL;
      ready_r <= 1'b0;
      read_seen_r <= 1'b0;
      settling_r <= 1'b1;
      wake_lan_enable_r <= 1'b0;
      energy_detect_enable_r <= 1'b0;
      buf_type_r <= 1'b0;
      wstat_r <= 2'h0;
      pulse_sel_r <= 1'b0;
      pol_r <= 1'b0;
      out_en_r <= 1'b0;
    end else begin
      // power-up: ready sets on the first clock after reset, without a settle wait
      if (settling_r && !settle_busy && !wake_req) begin
        settling_r <= 1'b0;
        ready_r <= 1'b1;
      end
      if (rd_go) begin
        read_seen_r <= 1'b1;
      end
      // wake: back to normal, ready after the settle time
      if (wake_req) begin
        state_r <= `PMW_STATE_NORMAL;
        read_seen_r <= 1'b0;
      end else if (settle_done) begin
        ready_r <= 1'b1;
      end else if (wr_ok && ap_addr_r == `PMW_ADDR_PM_CTRL) begin
        if (hwdata[`PMW_BIT_STATE_HI:`PMW_BIT_STATE_LO] != `PMW_STATE_RESERVED) begin
          state_r <= hwdata[`PMW_BIT_STATE_HI:`PMW_BIT_STATE_LO];
          if (hwdata[`PMW_BIT_STATE_HI:`PMW_BIT_STATE_LO] != `PMW_STATE_NORMAL) begin
            ready_r <= 1'b0;
          end
        end
        wake_lan_enable_r <= hwdata[`PMW_BIT_WAKE_LAN_ENABLE];
        energy_detect_enable_r <= hwdata[`PMW_BIT_ENERGY_DETECT_ENABLE];
        buf_type_r <= hwdata[`PMW_BIT_BUF_TYPE];
        pulse_sel_r <= hwdata[`PMW_BIT_PULSE_SEL];
        pol_r <= hwdata[`PMW_BIT_POL];
        out_en_r <= hwdata[`PMW_BIT_OUT_EN];
      end
      // an event wins over a same-cycle clear
      wstat_r <= (wstat_r & ~ws_clr) | {ev_new[1], ev_new[0]};
    end
  end

  // ******************************************************
  // wake output and interrupt
  // ******************************************************
  // static level follows status and enables; pulse follows its timer
  assign ev_any = (wstat_r[1] && wake_lan_enable_r) || (wstat_r[0] && energy_detect_enable_r);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_r <= 1'b0;
    end else if (pulse_sel_r) begin
      active_r <= pulse_busy && !pulse_done && ev_any;
    end else begin
      active_r <= ev_any;
    end
  end

  assign assert_lvl = buf_type_r ? pol_r : 1'b0;

  // drive the pin: push-pull drives whenever out_en_r is set, open-drain drives low when active and out_en_r is set
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_out_o <= 1'b0;
      wake_out_oe <= 1'b0;
      wake_interrupt <= 1'b0;
      transceiver_reset <= 1'b0;
      power_state <= `PMW_STATE_NORMAL;
    end else begin
      wake_interrupt <= ev_any;
      transceiver_reset <= xr_busy;
      power_state <= state_r;
      if (buf_type_r) begin
        wake_out_oe <= out_en_r;
        wake_out_o <= (active_r && out_en_r) ? assert_lvl : !assert_lvl;
      end else begin
        wake_out_oe <= active_r && out_en_r;
        wake_out_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/pmw_wake_monitor.sv
// Purpose: timing checks on the power and wake control block ports
// Assumes: single hclk domain, hresetn asynchronous active low
// Notes: helper counters measure transceiver reset length and gaps
`timescale 1ns/1ps
`default_nettype none
`include "pmw_defines.vh"
module pmw_wake_monitor (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // bus
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  // pins and state
  input wire wake_frame_evt,
  input wire energy_evt,
  input wire wake_interrupt,
  input wire transceiver_reset,
  input wire [1:0] power_state
);
  logic taken;
  logic wr_dp_r;
  logic [15:0] xr_cnt_r;
  logic [3:0] evt_gap_r;
  logic [3:0] wr_gap_r;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  assign taken = hsel && htrans[1] && hready;
  // reset length and cycles since the last event or write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dp_r <= 1'b0;
      xr_cnt_r <= 16'h0000;
      evt_gap_r <= 4'hF;
      wr_gap_r <= 4'hF;
    end else begin
      wr_dp_r <= taken && hwrite;
      xr_cnt_r <= transceiver_reset ? xr_cnt_r + 16'h0001 : 16'h0000;
      evt_gap_r <= (energy_evt || wake_frame_evt) ? 4'h0 : evt_gap_r + {3'h0, evt_gap_r != 4'hF};
      wr_gap_r <= wr_dp_r ? 4'h0 : wr_gap_r + {3'h0, wr_gap_r != 4'hF};
    end
  end
  sequence s_bt_wr;
    taken && hwrite && haddr == `PMW_ADDR_BYTE_TEST && power_state != 2'h0;
  endsequence
  sequence s_ctl_rd_low;
    taken && !hwrite && haddr == `PMW_ADDR_PM_CTRL && power_state != 2'h0;
  endsequence
  property p_resp_okay;
    taken && hwrite |=> hreadyout && !hresp;
  endproperty
  sequence s_rd_answer;
    !hreadyout ##1 hreadyout && !hresp;
  endsequence
  property p_rd_wait;
    taken && !hwrite |=> s_rd_answer;
  endproperty
  property p_state_legal;
    power_state != `PMW_STATE_RESERVED;
  endproperty
  property p_xr_min;
    $fell(transceiver_reset) |-> xr_cnt_r >= `PMW_XCVR_RST_CYC;
  endproperty
  property p_xr_max;
    xr_cnt_r <= `PMW_XCVR_RST_CYC + 4;
  endproperty
  property p_int_cause;
    $rose(wake_interrupt) |-> evt_gap_r <= 4'h8;
  endproperty
  property p_int_fall;
    $fell(wake_interrupt) |-> wr_gap_r <= 4'h4;
  endproperty
  property p_wake;
    s_bt_wr |-> ##[1:3] power_state == 2'h0;
  endproperty
  property p_nr_read;
    s_ctl_rd_low |=> ##1 hrdata[0] == 1'b0;
  endproperty
  a_resp_okay: assert property (p_resp_okay) else $error("bus answer not okay");
  a_rd_wait: assert property (p_rd_wait) else $error("read answer late");
  a_state_legal: assert property (p_state_legal) else $error("reserved state");
  a_xr_min: assert property (p_xr_min) else $error("reset too short");
  a_xr_max: assert property (p_xr_max) else $error("reset restarted");
  a_int_cause: assert property (p_int_cause) else $error("interrupt w/o event");
  a_int_fall: assert property (p_int_fall) else $error("interrupt dropped");
  a_wake: assert property (p_wake) else $error("no wake on byte test");
  a_nr_read: assert property (p_nr_read) else $error("ready set in low state");
endmodule
bind pmw_wake_ctrl pmw_wake_monitor pmw_wake_monitor_inst (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .wake_frame_evt(wake_frame_evt),
  .energy_evt(energy_evt), .wake_interrupt(wake_interrupt),
  .transceiver_reset(transceiver_reset), .power_state(power_state));
`default_nettype wire

// ### tb/pmw_pin_model.sv
// Purpose: far side of the wake pin and the event sources
// Assumes: wake line has a pull-up on the board
// Notes: event pins follow the bench requests as levels
`timescale 1ns/1ps
`default_nettype none
module pmw_pin_model (
  // pin drive from the block
  input wire logic wake_out_o,
  input wire logic wake_out_oe,
  // event requests
  input wire logic energy_req,
  input wire logic frame_req,
  // resolved line and event pins
  output wire logic wake_out_in,
  output wire logic energy_evt,
  output wire logic wake_frame_evt
);
  // pull-up holds the shared line high when undriven
  assign wake_out_in = wake_out_oe ? wake_out_o : 1'b1;
  // sources stay active until the far side withdraws them
  assign energy_evt = energy_req;
  assign wake_frame_evt = frame_req;
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Purpose: self-checking bench for the power and wake control block
// Assumes: AHB-Lite single word transfers, 100 MHz hclk
// Notes: pulse shortened to 20 cycles
`timescale 1ns/1ps
`default_nettype none
`include "pmw_defines.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  localparam logic [7:0] CTL = `PMW_ADDR_PM_CTRL;
  localparam logic [7:0] BT = `PMW_ADDR_BYTE_TEST;
  logic hclk, hresetn, hwrite, hreadyout, hresp, energy_req, frame_req;
  logic [7:0] haddr;
  logic [1:0] htrans, power_state;
  logic [31:0] hwdata, hrdata, rdata;
  wire logic wake_out_o, wake_out_oe, wake_out_in, wake_interrupt, transceiver_reset;
  wire logic energy_evt, wake_frame_evt;
  int bad_count, n_tests, cyc, s;
  pmw_wake_ctrl #(.PULSE_CYC(20), .SETTLE_CYC(16)) pmw_wake_ctrl_inst (.hclk(hclk),
    .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .wake_frame_evt(wake_frame_evt),
    .energy_evt(energy_evt), .wake_out_in(wake_out_in), .wake_out_o(wake_out_o),
    .wake_out_oe(wake_out_oe), .wake_interrupt(wake_interrupt),
    .transceiver_reset(transceiver_reset), .power_state(power_state));
  pmw_pin_model pmw_pin_model_inst (.wake_out_o(wake_out_o), .wake_out_oe(wake_out_oe),
    .energy_req(energy_req), .frame_req(frame_req), .wake_out_in(wake_out_in),
    .energy_evt(energy_evt), .wake_frame_evt(wake_frame_evt));
  // one single-word transfer, waiting on hready at both phases
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdata = hrdata;
  endtask
  // wait, then settle to the falling edge for pin checks
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // hang guard
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      final_report;
    end
  end
  // main sequence
  initial begin
    hresetn = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
    energy_req = 1'b0;
    frame_req = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (30) @(posedge hclk);
    bus(CTL, 1, 32'h00000306);
    bus(CTL, 0, 0);
    `CHK(rdata, 32'h00000001)
    bus(BT, 0, 0);
    `CHK(rdata, `PMW_BYTE_TEST_VAL)
    bus(8'h74, 0, 0);
    `CHK(rdata, 32'h00000000)
    bus(8'hF0, 0, 0);
    `CHK(rdata, 32'h00000000)
    // push-pull, active high, both events enabled, static
    bus(CTL, 1, 32'h00000346);
    energy_req <= 1'b1;
    wt(10);
    `CHK({wake_interrupt, wake_out_oe, wake_out_o}, 3'h7)
    bus(CTL, 0, 0);
    `CHK(rdata, 32'h00000357)
    frame_req <= 1'b1;
    wt(10);
    bus(CTL, 1, 32'h00000376);
    bus(CTL, 0, 0);
    `CHK(rdata, 32'h00000377)
    energy_req <= 1'b0;
    frame_req <= 1'b0;
    wt(10);
    bus(CTL, 1, 32'h00000356);
    bus(CTL, 0, 0);
    `CHK(rdata, 32'h00000367)
    bus(CTL, 1, 32'h00000366);
    wt(3);
    `CHK({wake_interrupt, wake_out_oe, wake_out_o}, 3'h2)
    // open-drain, pulsed, polarity bit left clear
    bus(CTL, 1, 32'h0000030A);
    energy_req <= 1'b1;
    wt(8);
    `CHK({wake_out_oe, wake_out_o, wake_out_in}, 3'h4)
    wt(30);
    `CHK({wake_interrupt, wake_out_oe, wake_out_in}, 3'h5)
    bus(CTL, 1, 32'h00000300);
    wt(3);
    `CHK({wake_interrupt, wake_out_oe}, 2'h2)
    bus(CTL, 1, 32'h00000200);
    wt(3);
    `CHK(wake_interrupt, 1'b0)
    energy_req <= 1'b0;
    wt(10);
    bus(CTL, 1, 32'h00000010);
    bus(CTL, 0, 0);
    `CHK(rdata, 32'h00000001)
    // self-timed transceiver reset
    bus(CTL, 1, 32'h00000400);
    wt(2);
    `CHK(transceiver_reset, 1'b1)
    bus(CTL, 1, 32'h00000400);
    bus(CTL, 0, 0);
    `CHK(rdata[10], 1'b1)
    wt(9950);
    `CHK(transceiver_reset, 1'b1)
    wt(60);
    `CHK(transceiver_reset, 1'b0)
    // each reduced state, then wake by byte test write
    for (s = 1; s < 3; s++) begin
      bus(CTL, 1, 32'(s) << 12);
      wt(2);
      `CHK(power_state, 2'(s))
      bus(CTL, 0, 0);
      `CHK(rdata[13:0], {2'(s), 12'h000})
      bus(BT, 1, 0);
      wt(2);
      `CHK(power_state, 2'h0)
      wt(30);
      bus(CTL, 1, 32'h00000300);
      bus(CTL, 0, 0);
      `CHK(rdata, 32'h00000001)
    end
    final_report;
  end
endmodule
`default_nettype wire
